// ---- common/fcc_consts.svh ----
`ifndef FCC_CONSTS_SVH
`define FCC_CONSTS_SVH

// Register addresses on the management port
`define FCC_ADDR_CHECKER_ENABLE 16'h9403
`define FCC_ADDR_CHECKER_IRQ_EN 16'h9406
`define FCC_ADDR_PATH_SELECT 16'h9407
`define FCC_ADDR_MAX_FRAME_LEN 16'h9408
`define FCC_ADDR_FRAME_CNT_HIGH 16'h940A
`define FCC_ADDR_FRAME_CNT_LOW 16'h940B
`define FCC_ADDR_LEN_ERR_CNT 16'h940C
`define FCC_ADDR_ALGN_ERR_CNT 16'h940D
`define FCC_ADDR_SYMB_ERR_CNT 16'h940E
`define FCC_ADDR_RX_ERR_COUNTER 16'h0014

// Reset values
`define FCC_RST_CHECKER_ENABLE 1'h1
`define FCC_RST_CHECKER_IRQ_EN 1'h1
`define FCC_RST_PATH_SELECT 1'h0
`define FCC_RST_MAX_FRAME_LEN 16'h05F2
`define FCC_RST_COUNT 16'h0000

// Field positions and widths
`define FCC_BIT_ENABLE 0
`define FCC_REG_W 16
`define FCC_FRAME_CNT_W 32
`define FCC_NUM_ERR 3

// Error counter indices
`define FCC_ERR_LEN 0
`define FCC_ERR_ALGN 1
`define FCC_ERR_SYMB 2

// Start frame delimiter octet ending the preamble
`define FCC_SFD_OCTET 8'hD5

`endif

// ---- common/fcc_pkg.sv ----
package fcc_pkg;

    typedef logic [15:0] fcc_word_t;
    typedef logic [7:0] fcc_octet_t;

    typedef enum logic [2:0] {
        FCC_IDLE = 3'h1,
        FCC_PREAMBLE = 3'h2,
        FCC_BODY = 3'h4
    } fcc_state_e;

endpackage

// ---- verilog/fcc_frame_checker.sv ----
// Functional notes
// - Path bit 0: 1 checks MAC transmit frames, 0 remote frames.
// - Path select resets to zero, so remote frames are checked.
// - 16-bit max frame length, reset 0x5F2; longer frames are oversized.
// - Oversize length excludes preamble and start frame delimiter.
// - 32-bit frame count; high copy reads latched bits 31..16.
// - Low copy reads latched bits 15..0 of the frame count.
// - Reading the receive error counter snapshots all counts at once.
// - 16-bit length error frame count, read through a latched copy.
// - 16-bit alignment error frame count, read through a latched copy.
// - 16-bit count of frames with error and valid both high.
// - All latched copies, high frame count included, reset to zero.
// - Frames open only while enabled, an open one runs to its end; the enable bit resets to one.
// - With interrupt enable set, a frame receive error raises a request.
`include "fcc_consts.svh"
`timescale 1ns/100ps
`default_nettype none

module fcc_frame_checker (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic [15:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire fcc_pkg::fcc_word_t reg_wdata,
    output logic [15:0] reg_rdata,
    input wire logic mac_tx_en,
    input wire logic mac_tx_er,
    input wire fcc_pkg::fcc_octet_t mac_txd,
    input wire logic phy_rx_dv,
    input wire logic phy_rx_er,
    input wire fcc_pkg::fcc_octet_t phy_rxd,
    input wire logic frame_len_err,
    input wire logic frame_algn_err,
    output logic frame_oversize,
    output logic checker_irq
);
    import fcc_pkg::*;

    function automatic logic addr_hit(
        input logic [15:0] addr,
        input logic [15:0] target
    );
        addr_hit = (addr == target);
    endfunction

    fcc_state_e state_reg;
    fcc_state_e state_next;
    logic checker_enable_reg;
    logic checker_interrupt_enable_reg;
    logic checked_path_select_reg;
    logic [15:0] max_frame_length_reg;
    logic [15:0] body_len_reg;
    logic [15:0] body_len_next;
    logic symb_seen_reg;
    logic [31:0] frame_cnt_reg;
    logic [31:0] frame_cnt_copy_reg;
    // Error count copies are gathered into one array for the read mux
    wire logic [15:0] err_copy [`FCC_NUM_ERR];
    logic [15:0] reg_rdata_reg;
    logic frame_oversize_reg;
    logic checker_irq_reg;

    wire logic chk_dv;
    wire logic chk_er;
    wire fcc_octet_t chk_data;
    wire logic wr_enable;
    wire logic wr_irq_en;
    wire logic wr_path;
    wire logic wr_max_len;
    wire logic snapshot;
    wire logic frame_end;
    wire logic frame_symb;
    wire logic [`FCC_NUM_ERR-1:0] err_event;
    wire logic [15:0] rd_value;
    wire logic hit_enable;
    wire logic hit_irq_en;
    wire logic hit_path;
    wire logic hit_max_len;
    wire logic hit_cnt_high;
    wire logic hit_cnt_low;
    wire logic hit_len_err;
    wire logic hit_algn_err;
    wire logic hit_symb_err;
    wire logic frame_start;
    wire logic symb_seen_next;

    // Switching paths mid-frame is not guarded; change it between frames
    // stream select
    assign chk_dv = checked_path_select_reg ? mac_tx_en : phy_rx_dv;
    assign chk_er = checked_path_select_reg ? mac_tx_er : phy_rx_er;
    assign chk_data = checked_path_select_reg ? mac_txd : phy_rxd;

    // Each address is decoded once; the writable ones are shared by write and read paths
    assign hit_enable = addr_hit(reg_addr, `FCC_ADDR_CHECKER_ENABLE);
    assign hit_irq_en = addr_hit(reg_addr, `FCC_ADDR_CHECKER_IRQ_EN);
    assign hit_path = addr_hit(reg_addr, `FCC_ADDR_PATH_SELECT);
    assign hit_max_len = addr_hit(reg_addr, `FCC_ADDR_MAX_FRAME_LEN);
    assign hit_cnt_high = addr_hit(reg_addr, `FCC_ADDR_FRAME_CNT_HIGH);
    assign hit_cnt_low = addr_hit(reg_addr, `FCC_ADDR_FRAME_CNT_LOW);
    assign hit_len_err = addr_hit(reg_addr, `FCC_ADDR_LEN_ERR_CNT);
    assign hit_algn_err = addr_hit(reg_addr, `FCC_ADDR_ALGN_ERR_CNT);
    assign hit_symb_err = addr_hit(reg_addr, `FCC_ADDR_SYMB_ERR_CNT);

    // Writes to the read-only copies fall through and are ignored
    assign wr_enable = reg_wr & hit_enable;
    assign wr_irq_en = reg_wr & hit_irq_en;
    assign wr_path = reg_wr & hit_path;
    assign wr_max_len = reg_wr & hit_max_len;
    assign snapshot = reg_rd & addr_hit(reg_addr, `FCC_ADDR_RX_ERR_COUNTER);

    // A frame opens only while enabled; one already open runs to its end
    assign frame_start =
        (state_reg == FCC_IDLE) & checker_enable_reg & chk_dv;
    // A frame is only counted once its delimiter has been seen
    assign frame_end = (state_reg == FCC_BODY) & ~chk_dv;
    assign frame_symb = symb_seen_reg | (chk_dv & chk_er);
    // A symbol error on the very first octet belongs to the frame too
    assign symb_seen_next =
        (state_reg == FCC_IDLE) ? (frame_start & chk_er) : frame_symb;

    assign err_event[`FCC_ERR_LEN] = frame_end & frame_len_err;
    assign err_event[`FCC_ERR_ALGN] = frame_end & frame_algn_err;
    assign err_event[`FCC_ERR_SYMB] = frame_end & symb_seen_reg;

    // Unmapped addresses and the snapshot address read as zero
    assign rd_value =
        hit_enable ?
            {15'h0000, checker_enable_reg} :
        hit_irq_en ?
            {15'h0000, checker_interrupt_enable_reg} :
        hit_path ?
            {15'h0000, checked_path_select_reg} :
        hit_max_len ?
            max_frame_length_reg :
        hit_cnt_high ?
            frame_cnt_copy_reg[31:16] :
        hit_cnt_low ?
            frame_cnt_copy_reg[15:0] :
        hit_len_err ?
            err_copy[`FCC_ERR_LEN] :
        hit_algn_err ?
            err_copy[`FCC_ERR_ALGN] :
        hit_symb_err ?
            err_copy[`FCC_ERR_SYMB] :
        16'h0000;

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            FCC_IDLE: begin
                if (frame_start) begin
                    state_next = (chk_data == `FCC_SFD_OCTET) ?
                        FCC_BODY : FCC_PREAMBLE;
                end
            end
            FCC_PREAMBLE: begin
                if (!chk_dv) begin
                    state_next = FCC_IDLE;
                end else if (chk_data == `FCC_SFD_OCTET) begin
                    state_next = FCC_BODY;
                end
            end
            FCC_BODY: begin
                if (!chk_dv) begin
                    state_next = FCC_IDLE;
                end
            end
            default: begin
                state_next = FCC_IDLE;
            end
        endcase
    end

    // Saturation keeps a huge frame from wrapping back under the limit
    // count body octets only, saturating
    assign body_len_next =
        (state_reg != FCC_BODY) ? 16'h0000 :
        (chk_dv && body_len_reg != 16'hFFFF) ? body_len_reg + 16'h0001 :
        body_len_reg;

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_reg <= FCC_IDLE;
            body_len_reg <= 16'h0000;
            symb_seen_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            body_len_reg <= body_len_next;
            symb_seen_reg <= symb_seen_next;
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            checked_path_select_reg <= `FCC_RST_PATH_SELECT;
            checker_enable_reg <= `FCC_RST_CHECKER_ENABLE;
            checker_interrupt_enable_reg <= `FCC_RST_CHECKER_IRQ_EN;
        end else begin
            if (wr_path) begin
                checked_path_select_reg <= reg_wdata[`FCC_BIT_ENABLE];
            end
            if (wr_enable) begin
                checker_enable_reg <= reg_wdata[`FCC_BIT_ENABLE];
            end
            if (wr_irq_en) begin
                checker_interrupt_enable_reg <= reg_wdata[`FCC_BIT_ENABLE];
            end
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            max_frame_length_reg <= `FCC_RST_MAX_FRAME_LEN;
        end else if (wr_max_len) begin
            max_frame_length_reg <= reg_wdata;
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            frame_cnt_reg <= 32'h00000000;
        end else if (frame_end) begin
            frame_cnt_reg <= frame_cnt_reg + 32'h00000001;
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            frame_cnt_copy_reg <= 32'h00000000;
        end else if (snapshot) begin
            frame_cnt_copy_reg <= frame_cnt_reg;
        end
    end

    // Running counters wrap; copy takes the value before this cycle's event
    genvar gi;
    generate
        for (gi = 0; gi < `FCC_NUM_ERR; gi = gi + 1) begin : g_err
            logic [15:0] cnt_reg;
            logic [15:0] copy_reg;
            always_ff @(posedge sys_clk or posedge sys_rst) begin
                if (sys_rst) begin
                    cnt_reg <= `FCC_RST_COUNT;
                end else if (err_event[gi]) begin
                    cnt_reg <= cnt_reg + 16'h0001;
                end
            end
            always_ff @(posedge sys_clk or posedge sys_rst) begin
                if (sys_rst) begin
                    copy_reg <= `FCC_RST_COUNT;
                end else if (snapshot) begin
                    copy_reg <= cnt_reg;
                end
            end
            assign err_copy[gi] = copy_reg;
        end
    endgenerate

    // A pulse only; any latching belongs to the interrupt status logic
    // error request
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            checker_irq_reg <= 1'b0;
            frame_oversize_reg <= 1'b0;
        end else begin
            checker_irq_reg <= checker_interrupt_enable_reg &
                (|err_event);
            frame_oversize_reg <= frame_end &
                (body_len_reg > max_frame_length_reg);
        end
    end

    // Read data is registered, so it appears one edge after reg_rd
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            reg_rdata_reg <= 16'h0000;
        end else if (reg_rd) begin
            reg_rdata_reg <= rd_value;
        end
    end

    assign reg_rdata = reg_rdata_reg;
    assign frame_oversize = frame_oversize_reg;
    assign checker_irq = checker_irq_reg;

endmodule

`default_nettype wire

// ---- bench/fcc_frame_checker_props.sv ----
`timescale 1ns/100ps
`default_nettype none
module fcc_frame_checker_props (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic [15:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire fcc_pkg::fcc_word_t reg_wdata,
    input wire logic [15:0] reg_rdata,
    input wire logic mac_tx_en,
    input wire logic phy_rx_dv,
    input wire logic frame_oversize,
    input wire logic checker_irq
);
    logic sel_reg;
    logic [15:0] max_reg;
    wire logic vsel;
    assign vsel = sel_reg ? mac_tx_en : phy_rx_dv;
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sel_reg <= 1'b0;
            max_reg <= 16'h05F2;
        end else if (reg_wr && reg_addr == 16'h9407) begin
            sel_reg <= reg_wdata[0];
        end else if (reg_wr && reg_addr == 16'h9408) begin
            max_reg <= reg_wdata;
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    rst_rdata_a:
    assert property ($fell(sys_rst) |-> reg_rdata == 16'h0000)
    else $error("read data not clear after reset");
    snap_read_a:
    assert property (reg_rd && reg_addr == 16'h0014 |=> reg_rdata == 16'h0)
    else $error("snapshot read data not zero");
    rdata_hold_a:
    assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved without a read");
    osz_pulse_a:
    assert property (frame_oversize |=> !frame_oversize)
    else $error("oversize pulse too long");
    irq_pulse_a:
    assert property (checker_irq |=> !checker_irq)
    else $error("request pulse too long");
    osz_end_a:
    assert property (frame_oversize |-> $past(vsel, 2) && !$past(vsel))
    else $error("oversize not at frame end");
    irq_end_a:
    assert property (checker_irq |-> $past(vsel, 2) && !$past(vsel))
    else $error("request not at frame end");
    max_rd_a:
    assert property (reg_rd && reg_addr == 16'h9408 |=>
        reg_rdata == max_reg)
    else $error("max length readback wrong");
    sel_rd_a:
    assert property (reg_rd && reg_addr == 16'h9407 |=>
        reg_rdata == {15'h0, sel_reg})
    else $error("path select readback wrong");
    cover property (frame_oversize);
    cover property (checker_irq);
    cover property (reg_rd && reg_addr == 16'h0014);
endmodule
`default_nettype wire

// ---- bench/fcc_frame_src.sv ----
`timescale 1ns/100ps
`default_nettype none
module fcc_frame_src (
    input wire logic clk,
    output logic dv,
    output logic er,
    output logic [7:0] d,
    output logic len_err,
    output logic algn_err
);
    initial begin
        dv = 1'b0;
        er = 1'b0;
        d = 8'hA5;
        len_err = 1'b0;
        algn_err = 1'b0;
    end
    // Idle octets keep toggling so a stale value never looks like a frame
    task automatic send(input int n, input int er_at, input logic le,
                        input logic ae);
        int i;
        for (i = 0; i < n + 10; i++) begin
            @(posedge clk) #1;
            dv = (i < n + 8);
            d = (i < 7) ? 8'h55 : (i == 7) ? 8'hD5 : ~d;
            er = (i == er_at);
            len_err = (i == n + 8) & le;
            algn_err = (i == n + 8) & ae;
        end
    endtask
endmodule
`default_nettype wire

// ---- bench/tb_top.sv ----
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import fcc_pkg::*;
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [15:0] reg_addr = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    fcc_word_t reg_wdata = 16'h0000;
    logic [15:0] reg_rdata;
    logic mac_tx_en, mac_tx_er, phy_rx_dv, phy_rx_er, le_m, ae_m, le_p, ae_p;
    fcc_octet_t mac_txd, phy_rxd;
    logic frame_oversize, checker_irq;
    logic path = 1'b0;
    int error_cnt = 0;
    int n_checks = 0;
    int osz = 0;
    int irq = 0;
    wire logic frame_len_err = path ? le_m : le_p;
    wire logic frame_algn_err = path ? ae_m : ae_p;
    always #50 sys_clk = ~sys_clk;
    fcc_frame_src mac_src (.clk(sys_clk), .dv(mac_tx_en), .er(mac_tx_er),
        .d(mac_txd), .len_err(le_m), .algn_err(ae_m));
    fcc_frame_src phy_src (.clk(sys_clk), .dv(phy_rx_dv), .er(phy_rx_er),
        .d(phy_rxd), .len_err(le_p), .algn_err(ae_p));
    fcc_frame_checker fcc_frame_checker_inst (.sys_clk(sys_clk),
        .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .mac_tx_en(mac_tx_en), .mac_tx_er(mac_tx_er), .mac_txd(mac_txd),
        .phy_rx_dv(phy_rx_dv), .phy_rx_er(phy_rx_er), .phy_rxd(phy_rxd),
        .frame_len_err(frame_len_err), .frame_algn_err(frame_algn_err),
        .frame_oversize(frame_oversize), .checker_irq(checker_irq));
    always @(posedge sys_clk) begin
        if (frame_oversize === 1'b1) osz++;
        if (checker_irq === 1'b1) irq++;
    end
    task automatic final_report;
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("[FAIL] %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge sys_clk) #1;
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(posedge sys_clk) #1;
        reg_wr = 1'b0;
    endtask
    task automatic rc(input logic [15:0] a, input logic [15:0] e);
        @(posedge sys_clk) #1;
        reg_addr = a;
        reg_rd = 1'b1;
        @(posedge sys_clk) #1;
        reg_rd = 1'b0;
        chk(reg_rdata, e);
    endtask
    task automatic copies(input bit snap, input logic [15:0] f, l, a, s);
        if (snap) rc(16'h0014, 16'h0000);
        rc(16'h940A, 16'h0000);
        rc(16'h940B, f);
        rc(16'h940C, l);
        rc(16'h940D, a);
        rc(16'h940E, s);
    endtask
    task automatic fr(input bit mac, input int n, er_at, input logic le, ae);
        if (mac) mac_src.send(n, er_at, le, ae);
        else phy_src.send(n, er_at, le, ae);
    endtask
    initial begin
        #500000;
        error_cnt++;
        final_report;
    end
    initial begin
        repeat (12) @(posedge sys_clk);
        #1 sys_rst = 1'b0;
        rc(16'h9403, 16'h0001);
        rc(16'h9406, 16'h0001);
        rc(16'h9407, 16'h0000);
        rc(16'h9408, 16'h05F2);
        rc(16'h9409, 16'h0000);
        copies(1'b0, 0, 0, 0, 0);
        wr(16'h9408, 16'h0010);
        wr(16'h940B, 16'h1234);
        rc(16'h9408, 16'h0010);
        rc(16'h940B, 16'h0000);
        $display("test registers done");
        fork
            fr(1'b0, 16, -1, 1'b0, 1'b0);
            fr(1'b1, 20, 9, 1'b1, 1'b0);
        join
        fr(1'b0, 17, -1, 1'b1, 1'b0);
        fr(1'b0, 16, -1, 1'b0, 1'b1);
        fr(1'b0, 10, 12, 1'b0, 1'b0);
        fr(1'b0, 10, 0, 1'b0, 1'b0);
        // Let the last frame's pulses reach the counters first
        repeat (2) @(posedge sys_clk);
        #1;
        chk(osz, 1);
        chk(irq, 4);
        copies(1'b1, 5, 1, 1, 2);
        $display("test far frames done");
        // MAC path stream stands for looped-back data
        wr(16'h9407, 16'h0001);
        path = 1'b1;
        wr(16'h9406, 16'h0000);
        fork
            fr(1'b1, 12, 10, 1'b0, 1'b0);
            fr(1'b0, 12, -1, 1'b1, 1'b0);
        join
        repeat (2) @(posedge sys_clk);
        #1;
        chk(irq, 4);
        copies(1'b0, 5, 1, 1, 2);
        wr(16'h9403, 16'h0000);
        fr(1'b1, 12, -1, 1'b1, 1'b0);
        copies(1'b1, 6, 1, 1, 3);
        $display("test mac path done");
        final_report;
    end
endmodule
bind fcc_frame_checker fcc_frame_checker_props fcc_frame_checker_props_inst (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .mac_tx_en(mac_tx_en), .phy_rx_dv(phy_rx_dv),
    .frame_oversize(frame_oversize), .checker_irq(checker_irq));
`default_nettype wire
